// File: design/sepw_pkg.sv
// Shared constants and types of the serial EEPROM client and its bus host.
// Assumes both ends run on one core clock and meet in sepw_if.
package sepw_pkg;
	localparam logic [3:0]  DEV_CODE         = 4'ha;
	localparam int          MEM_DEPTH        = 128;
	localparam int          ADDR_W           = 7;
	localparam int          PAGE_W           = 4;
	localparam logic [3:0]  ACK_SLOT         = 4'h8;
	localparam int          WRITE_CYCLES_DEF = 2000;
	localparam logic [5:0]  SYNC_RST         = 6'h3f;
	localparam logic [6:0]  PTR_RST          = 7'h00;
	// Host register map, byte offsets on APB
	localparam logic [7:0]  REG_CMD          = 8'h00;
	localparam logic [7:0]  REG_TXDATA       = 8'h04;
	localparam logic [7:0]  REG_RXSTAT       = 8'h08;
	localparam logic [7:0]  REG_DIV          = 8'h0c;
	localparam int          CMD_ACK_BIT      = 8;
	localparam logic [15:0] DIV_RST          = 16'h0003;
	localparam logic [2:0]  CMD_START        = 3'h1;
	localparam logic [2:0]  CMD_STOP         = 3'h2;
	localparam logic [2:0]  CMD_WRITE        = 3'h3;
	localparam logic [2:0]  CMD_READ         = 3'h4;
	localparam logic [1:0]  PH_SAMPLE        = 2'h1;
	localparam logic [1:0]  PH_LAST_START    = 2'h3;
	localparam logic [1:0]  PH_LAST_STOP     = 2'h2;
	localparam logic [1:0]  PH_LAST_BIT      = 2'h2;
	localparam logic [3:0]  LAST_BIT         = 4'h8;

	typedef enum logic [2:0] {
		CS_IDLE, CS_CTRL, CS_WADDR, CS_WDATA, CS_RDATA, CS_SKIP
	} sepw_cst_type;

	typedef enum logic [1:0] {
		HS_IDLE, HS_START, HS_BIT, HS_STOP
	} sepw_hst_type;
endpackage : sepw_pkg

// File: design/sepw_if.sv
// Two-wire link between the bus host and the EEPROM client.
// Resolves the open-drain wire levels from each end's output and enable.
`timescale 1ns/10ps
interface sepw_if;
	logic hostSclOut;
	logic hostSclOe;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	wire  scl;
	wire  sda;

	// Enable low means the end pulls the wire to its output level
	assign scl = hostSclOe | hostSclOut;
	assign sda = (hostSdaOe | hostSdaOut) & (devSdaOe | devSdaOut);

	modport host(output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe, input scl, sda);
	modport client(output devSdaOut, devSdaOe, input scl, sda);
endinterface : sepw_if

// File: design/sepw_client.sv
// Client end: 128-byte EEPROM with page buffer, write protect and busy cycle.
// Assumes the host keeps to the two-wire protocol; all pins are asynchronous.
//
// Design decisions made here: the placing of the registers and the two-wire interface to the memory.
`timescale 1ns/10ps
module sepw_client #(
	parameter int WRITE_CYCLES = sepw_pkg::WRITE_CYCLES_DEF
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic writeProtect,
	input  wire logic chipSelectBit2,
	input  wire logic chipSelectBit1,
	input  wire logic chipSelectBit0,
	output      logic writeBusy,
	sepw_if.client    link
);
	localparam int TW   = $clog2(WRITE_CYCLES + 1);
	localparam int PAGE = 1 << sepw_pkg::PAGE_W;

	logic [5:0]             sync1_ff;
	logic [5:0]             sync2_ff;
	logic [1:0]             busD_ff;
	sepw_pkg::sepw_cst_type state_ff;
	sepw_pkg::sepw_cst_type nxt_state;
	logic [3:0]             cnt_ff;
	logic [7:0]             shift_ff;
	logic [6:0]             ptr_ff;
	logic [7:0]             tx_ff;
	logic                   oe_ff;
	logic                   busy_ff;
	logic [TW-1:0]          timer_ff;
	logic [PAGE-1:0]        valid_ff;
	logic [7:0]             pageBuf [PAGE];
	logic [7:0]             mem [sepw_pkg::MEM_DEPTH];

	// Straps pass the synchroniser too, so they may change at any time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= sepw_pkg::SYNC_RST;
			sync2_ff <= sepw_pkg::SYNC_RST;
			busD_ff  <= '1;
		end else begin
			sync1_ff <= {chipSelectBit2, chipSelectBit1, chipSelectBit0,
				writeProtect, link.sda, link.scl};
			sync2_ff <= sync1_ff;
			busD_ff  <= sync2_ff[1:0];
		end
	end

	wire       sclS      = sync2_ff[0];
	wire       sdaS      = sync2_ff[1];
	wire       wpS       = sync2_ff[2];
	wire [2:0] csS       = sync2_ff[5:3];
	wire       sclRise   = sclS & ~busD_ff[0];
	wire       sclFall   = ~sclS & busD_ff[0];
	wire       startCond = sclS & busD_ff[0] & busD_ff[1] & ~sdaS;
	wire       stopCond  = sclS & busD_ff[0] & ~busD_ff[1] & sdaS;
	wire       cnt8      = cnt_ff == sepw_pkg::ACK_SLOT;
	wire       ackRise   = sclRise & cnt8;
	wire       isCtrl    = state_ff == sepw_pkg::CS_CTRL;
	wire       isAddr    = state_ff == sepw_pkg::CS_WADDR;
	wire       isData    = state_ff == sepw_pkg::CS_WDATA;
	wire       isRd      = state_ff == sepw_pkg::CS_RDATA;
	wire       rwBit     = shift_ff[0];
	wire       ctrlMatch = (shift_ff[7:4] == sepw_pkg::DEV_CODE)
		& (shift_ff[3:1] == csS);
	// Busy gate covers the client address itself
	wire       ackMe     = (isCtrl & ctrlMatch & ~busy_ff) | isAddr | isData;
	wire       txBit     = tx_ff[3'd7 - cnt_ff[2:0]];
	wire       nxtOe     = cnt8 ? ~ackMe : ~(isRd & ~txBit);
	wire       loadTx    = ackRise & ((isCtrl & ackMe & rwBit) | (isRd & ~sdaS));
	wire       wrByte    = ackRise & isData;
	wire       commit    = stopCond & isData & (|valid_ff);
	wire [3:0] pageIdx   = ptr_ff[3:0];
	wire [2:0] pageBase  = ptr_ff[6:4];

	assign writeBusy    = busy_ff;
	assign link.devSdaOe  = oe_ff;
	assign link.devSdaOut = 1'b0;

	always_comb begin
		nxt_state = state_ff;
		if (startCond) begin
			nxt_state = sepw_pkg::CS_CTRL;
		end else if (stopCond) begin
			nxt_state = sepw_pkg::CS_IDLE;
		end else if (ackRise) begin
			case (state_ff)
				sepw_pkg::CS_CTRL: begin
					if (!ackMe) begin
						nxt_state = sepw_pkg::CS_SKIP;
					end else if (rwBit) begin
						nxt_state = sepw_pkg::CS_RDATA;
					end else begin
						nxt_state = sepw_pkg::CS_WADDR;
					end
				end
				sepw_pkg::CS_WADDR: begin
					nxt_state = sepw_pkg::CS_WDATA;
				end
				sepw_pkg::CS_RDATA: begin
					// Host nack ends the read; line stays released
					if (sdaS) begin
						nxt_state = sepw_pkg::CS_SKIP;
					end
				end
				default: begin
					nxt_state = state_ff;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= sepw_pkg::CS_IDLE;
			cnt_ff   <= '0;
			shift_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			if (startCond | stopCond) begin
				cnt_ff <= '0;
			end else if (sclRise) begin
				cnt_ff <= cnt8 ? 4'h0 : cnt_ff + 4'h1;
			end
			if (sclRise & ~cnt8) begin
				shift_ff <= {shift_ff[6:0], sdaS};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= sepw_pkg::PTR_RST;
			tx_ff  <= '0;
		end else if (ackRise & isAddr) begin
			// Top bit of the word address is a don't care
			ptr_ff <= shift_ff[6:0];
		end else if (loadTx) begin
			tx_ff  <= mem[ptr_ff];
			// Seven-bit pointer rolls from the top location to zero
			ptr_ff <= ptr_ff + 7'h01;
		end else if (wrByte) begin
			// Only the byte counter moves, so the page never changes
			ptr_ff <= {pageBase, pageIdx + 4'h1};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_ff <= 1'b1;
		end else if (startCond | stopCond) begin
			oe_ff <= 1'b1;
		end else if (sclFall) begin
			oe_ff <= nxtOe;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff  <= 1'b0;
			timer_ff <= '0;
		end else if (commit) begin
			busy_ff  <= 1'b1;
			timer_ff <= TW'(WRITE_CYCLES - 1);
		end else if (busy_ff) begin
			if (timer_ff == '0) begin
				busy_ff <= 1'b0;
			end else begin
				timer_ff <= timer_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_ff <= '0;
		end else if (startCond | stopCond) begin
			// A repeated Start abandons any buffered page data
			valid_ff <= '0;
		end else if (wrByte) begin
			valid_ff[pageIdx] <= 1'b1;
		end
	end

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge core_clk) begin
		if (wrByte) begin
			pageBuf[pageIdx] <= shift_ff;
		end
		// Protected write still runs the busy cycle but stores nothing
		if (commit & ~wpS) begin
			for (int i = 0; i < PAGE; i++) begin
				if (valid_ff[i]) begin
					mem[{pageBase, 4'(i)}] <= pageBuf[i];
				end
			end
		end
	end
endmodule : sepw_client

// File: design/sepw_host.sv
// Host end: APB-programmed two-wire bus host issuing Start, Stop and bytes.
// Assumes an APB master on core_clk; software sequences whole commands.
`timescale 1ns/10ps
module sepw_host (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	sepw_if.host             link
);
	logic [1:0]             sync1_ff;
	logic [1:0]             sync2_ff;
	sepw_pkg::sepw_hst_type hst_ff;
	sepw_pkg::sepw_hst_type cmdState;
	logic [1:0]             ph_ff;
	logic [1:0]             lastPh;
	logic [15:0]            tick_ff;
	logic [15:0]            div_ff;
	logic [3:0]             bit_ff;
	logic [8:0]             sh_ff;
	logic                   samp_ff;
	logic [7:0]             tx_ff;
	logic                   sclOe_ff;
	logic                   sdaOe_ff;
	logic                   wantScl;
	logic                   wantSda;
	logic [31:0]            prdata_ff;
	logic                   pready_ff;
	logic                   pslverr_ff;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
		end else begin
			sync1_ff <= {link.sda, link.scl};
			sync2_ff <= sync1_ff;
		end
	end

	wire        sdaS     = sync2_ff[1];
	wire        busy     = hst_ff != sepw_pkg::HS_IDLE;
	wire        apbAcc   = psel & penable;
	wire        apbWr    = apbAcc & pready_ff & pwrite;
	wire        selCmd   = paddr == sepw_pkg::REG_CMD;
	wire        selTx    = paddr == sepw_pkg::REG_TXDATA;
	wire        selRx    = paddr == sepw_pkg::REG_RXSTAT;
	wire        selDiv   = paddr == sepw_pkg::REG_DIV;
	wire        mapped   = selCmd | selTx | selRx | selDiv;
	wire        isBit    = hst_ff == sepw_pkg::HS_BIT;
	wire        phaseEnd = tick_ff == div_ff;
	// Commands written while a previous one runs are dropped
	wire        cmdGo    = apbWr & selCmd & ~busy & (cmdState != sepw_pkg::HS_IDLE);
	wire        sendAck  = pwdata[sepw_pkg::CMD_ACK_BIT];
	// Status: bit 9 busy, bit 8 acknowledge seen, 7:0 byte shifted in
	wire [31:0] rdMux    = selTx ? {24'h0, tx_ff}
		: selRx ? {22'h0, busy, ~sh_ff[0], sh_ff[8:1]}
		: selDiv ? {16'h0, div_ff} : 32'h0;

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign link.hostSclOe  = sclOe_ff;
	assign link.hostSclOut = 1'b0;
	assign link.hostSdaOe  = sdaOe_ff;
	assign link.hostSdaOut = 1'b0;

	always_comb begin
		case (pwdata[2:0])
			sepw_pkg::CMD_START: cmdState = sepw_pkg::HS_START;
			sepw_pkg::CMD_STOP:  cmdState = sepw_pkg::HS_STOP;
			sepw_pkg::CMD_WRITE: cmdState = sepw_pkg::HS_BIT;
			sepw_pkg::CMD_READ:  cmdState = sepw_pkg::HS_BIT;
			default:             cmdState = sepw_pkg::HS_IDLE;
		endcase
	end

	// Wire levels per phase; in bit phases SDA only moves while SCL is low, Start and Stop move it with SCL high
	always_comb begin
		wantScl = sclOe_ff;
		wantSda = sdaOe_ff;
		lastPh  = sepw_pkg::PH_LAST_BIT;
		case (hst_ff)
			sepw_pkg::HS_START: begin
				wantScl = (ph_ff == 2'h1) | (ph_ff == 2'h2);
				wantSda = ph_ff < 2'h2;
				lastPh  = sepw_pkg::PH_LAST_START;
			end
			sepw_pkg::HS_STOP: begin
				wantScl = ph_ff != 2'h0;
				wantSda = ph_ff == 2'h2;
				lastPh  = sepw_pkg::PH_LAST_STOP;
			end
			sepw_pkg::HS_BIT: begin
				wantScl = ph_ff == 2'h1;
				wantSda = sh_ff[8];
			end
			default: begin
				lastPh = sepw_pkg::PH_LAST_BIT;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hst_ff   <= sepw_pkg::HS_IDLE;
			ph_ff    <= '0;
			tick_ff  <= '0;
			bit_ff   <= '0;
			sh_ff    <= '1;
			samp_ff  <= 1'b1;
			sclOe_ff <= 1'b1;
			sdaOe_ff <= 1'b1;
		end else begin
			sclOe_ff <= wantScl;
			sdaOe_ff <= wantSda;
			if (cmdGo) begin
				hst_ff  <= cmdState;
				ph_ff   <= '0;
				tick_ff <= '0;
				bit_ff  <= '0;
				// Write: ninth bit released for the client's ack
				// Read: ninth bit is our ack, or nack before Stop
				sh_ff   <= (pwdata[2:0] == sepw_pkg::CMD_WRITE)
					? {tx_ff, 1'b1} : {8'hff, ~sendAck};
			end else if (busy) begin
				if (!phaseEnd) begin
					tick_ff <= tick_ff + 16'h1;
				end else begin
					tick_ff <= '0;
					if (isBit & (ph_ff == sepw_pkg::PH_SAMPLE)) begin
						samp_ff <= sdaS;
					end
					if (ph_ff != lastPh) begin
						ph_ff <= ph_ff + 2'h1;
					end else begin
						ph_ff <= '0;
						if (isBit) begin
							sh_ff  <= {sh_ff[7:0], samp_ff};
							bit_ff <= bit_ff + 4'h1;
						end
						if (!isBit | (bit_ff == sepw_pkg::LAST_BIT)) begin
							hst_ff <= sepw_pkg::HS_IDLE;
						end
					end
				end
			end
		end
	end

	// One wait state: answer registered in the first access cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
			tx_ff      <= '0;
			div_ff     <= sepw_pkg::DIV_RST;
		end else begin
			pready_ff <= apbAcc & ~pready_ff;
			if (apbAcc & ~pready_ff) begin
				prdata_ff  <= rdMux;
				pslverr_ff <= ~mapped;
			end
			if (apbWr & selTx) begin
				tx_ff <= pwdata[7:0];
			end
			if (apbWr & selDiv) begin
				div_ff <= pwdata[15:0];
			end
		end
	end
endmodule : sepw_host

// File: tb/sepw_chk.sv
// Checker of the two-wire link and the client's write-cycle flag.
// Assumes one core clock domain; instantiated beside the link interface.
`timescale 1ns/10ps
module sepw_chk #(
	parameter int WRITE_CYCLES = sepw_pkg::WRITE_CYCLES_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic writeBusy,
	input wire logic hostSclOut,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic sclPrev_ff;
	logic sdaPrev_ff;
	int   busyCnt_ff;
	int   sinceStop_ff;
	wire  stopEv  = scl & sclPrev_ff & sda & ~sdaPrev_ff;
	wire  startEv = scl & sclPrev_ff & ~sda & sdaPrev_ff;

	// Saturates so an idle bus cannot wrap back into range
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_ff   <= 1'b1;
			sdaPrev_ff   <= 1'b1;
			busyCnt_ff   <= 0;
			sinceStop_ff <= 1000;
		end else begin
			sclPrev_ff   <= scl;
			sdaPrev_ff   <= sda;
			busyCnt_ff   <= writeBusy ? busyCnt_ff + 1 : 0;
			sinceStop_ff <= stopEv ? 0 : (sinceStop_ff < 1000 ? sinceStop_ff + 1 : 1000);
		end
	end

	chk_busy_quiet: assert property (writeBusy |-> devSdaOe)
		else $error("client pulled sda during write cycle");
	chk_busy_length: assert property ($fell(writeBusy) |-> busyCnt_ff == WRITE_CYCLES)
		else $error("write cycle length wrong");
	chk_busy_after_stop: assert property ($rose(writeBusy) |-> sinceStop_ff <= 8)
		else $error("write cycle began without a stop");
	chk_busy_holds: assert property ($rose(writeBusy) |=> writeBusy [*7])
		else $error("write cycle ended early");
	chk_dev_scl_low: assert property ($changed(devSdaOe) |-> !scl)
		else $error("client changed sda while scl high");
	chk_start_by_host: assert property (startEv |-> !hostSdaOe)
		else $error("start condition not made by host");
	chk_stop_release: assert property (stopEv |=> devSdaOe [*4])
		else $error("client drives sda after stop");
	chk_open_drain: assert property (!(devSdaOut | hostSdaOut | hostSclOut))
		else $error("open-drain output level not low");
	// A client pulling sda with scl high would fake a Start for every device
	chk_dev_no_start: assert property (startEv |-> devSdaOe)
		else $error("client took part in a start condition");

	cover property ($rose(writeBusy));
	cover property ($fell(writeBusy));
	cover property (stopEv);
	cover property (startEv);
endmodule : sepw_chk

// File: tb/serial_eeprom_page_write_read_bench.sv
// Bench: APB-driven host talks to the EEPROM client over the link.
// Assumes the host's default divider; expectations from a memory model.
`timescale 1ns/10ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin miscompares++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module serial_eeprom_page_write_read_bench;
	localparam int WC = 300;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        writeProtect = 1'b0;
	logic [2:0]  cs = 3'h5;
	logic        writeBusy;
	logic [31:0] st;
	logic        slvErr;
	logic [7:0]  mem [128];
	logic [6:0]  ptr;
	integer      seed = 32'h74f9;
	int          miscompares = 0;
	int          nCompared = 0;

	sepw_if link();
	sepw_host sepw_host_i(.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	sepw_client #(.WRITE_CYCLES(WC)) sepw_client_i(.core_clk(core_clk), .rst_n(rst_n),
		.writeProtect(writeProtect), .chipSelectBit2(cs[2]), .chipSelectBit1(cs[1]),
		.chipSelectBit0(cs[0]), .writeBusy(writeBusy), .link(link));
	sepw_chk #(.WRITE_CYCLES(WC)) sepw_chk_i(.core_clk(core_clk), .rst_n(rst_n),
		.writeBusy(writeBusy), .hostSclOut(link.hostSclOut), .hostSdaOut(link.hostSdaOut),
		.hostSdaOe(link.hostSdaOe), .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe),
		.scl(link.scl), .sda(link.sda));

	always #10 core_clk = ~core_clk;

	function automatic logic [7:0] ctrl(input logic rd);
		return {sepw_pkg::DEV_CODE, cs, rd};
	endfunction : ctrl

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		st     = prdata;
		slvErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Busy bit guards against a command being dropped silently
	task automatic cmd(input logic ack, input logic [2:0] c);
		apb(1'b1, sepw_pkg::REG_CMD, {23'h0, ack, 5'h0, c});
		do apb(1'b0, sepw_pkg::REG_RXSTAT, 32'h0); while (st[9] !== 1'b0);
	endtask : cmd

	task automatic wbyte(input logic [7:0] b);
		apb(1'b1, sepw_pkg::REG_TXDATA, {24'h0, b});
		cmd(1'b0, sepw_pkg::CMD_WRITE);
	endtask : wbyte

	task automatic poll();
		int k;
		k = 0;
		do begin
			cmd(1'b0, sepw_pkg::CMD_START);
			wbyte(ctrl(1'b0));
			k++;
		end while (st[8] !== 1'b1 && k < 200);
		`CHK(st[8], 1'b1)
		`CHK(k > 1, 1'b1)
		cmd(1'b0, sepw_pkg::CMD_STOP);
	endtask : poll

	task automatic page_write(input logic [7:0] a, input int n);
		logic [7:0] d;
		logic [3:0] cnt;
		cmd(1'b0, sepw_pkg::CMD_START);
		wbyte(ctrl(1'b0));
		wbyte(a);
		cnt = a[3:0];
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			wbyte(d);
			`CHK(st[8], 1'b1)
			if (!writeProtect) mem[{a[6:4], cnt}] = d;
			cnt++;
		end
		cmd(1'b0, sepw_pkg::CMD_STOP);
		poll();
	endtask : page_write

	task automatic read_seq(input logic [6:0] a, input int n);
		cmd(1'b0, sepw_pkg::CMD_START);
		wbyte(ctrl(1'b0));
		wbyte({1'b1, a});
		cmd(1'b0, sepw_pkg::CMD_START);
		wbyte(ctrl(1'b1));
		ptr = a;
		for (int i = 0; i < n; i++) begin
			cmd(i < n - 1, sepw_pkg::CMD_READ);
			`CHK(st[7:0], mem[ptr])
			ptr++;
		end
		cmd(1'b0, sepw_pkg::CMD_STOP);
	endtask : read_seq

	task automatic final_report();
		if (miscompares == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	initial begin
		#1600000;
		miscompares++;
		final_report();
	end

	initial begin
		logic [6:0] a;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		apb(1'b0, 8'h10, 32'h0);
		`CHK(slvErr, 1'b1)
		apb(1'b0, sepw_pkg::REG_DIV, 32'h0);
		`CHK(st, {16'h0, sepw_pkg::DIV_RST})
		apb(1'b1, sepw_pkg::REG_DIV, 32'h0000_0005);
		apb(1'b0, sepw_pkg::REG_DIV, 32'h0);
		`CHK(st, 32'h0000_0005)
		apb(1'b1, sepw_pkg::REG_DIV, {16'h0, sepw_pkg::DIV_RST});
		// Unknown command code must be dropped, leaving the host idle
		apb(1'b1, sepw_pkg::REG_CMD, 32'h0000_0007);
		apb(1'b0, sepw_pkg::REG_RXSTAT, 32'h0);
		`CHK(st[9], 1'b0)
		apb(1'b0, sepw_pkg::REG_CMD, 32'h0);
		`CHK(st, 32'h0)
		apb(1'b1, sepw_pkg::REG_TXDATA, 32'h0000_005a);
		apb(1'b0, sepw_pkg::REG_TXDATA, 32'h0);
		`CHK(st, 32'h0000_005a)
		page_write(8'h70, 16);
		page_write(8'h00, 16);
		a = 7'($random(seed));
		page_write({1'b0, a}, 18);
		read_seq({a[6:4], 4'h0}, 16);
		read_seq(7'h7e, 4);
		cmd(1'b0, sepw_pkg::CMD_START);
		wbyte(ctrl(1'b1));
		cmd(1'b0, sepw_pkg::CMD_READ);
		`CHK(st[7:0], mem[ptr])
		cmd(1'b0, sepw_pkg::CMD_STOP);
		writeProtect <= 1'b1;
		repeat (4) @(posedge core_clk);
		page_write(8'h73, 5);
		read_seq(7'h70, 8);
		writeProtect <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			cmd(1'b0, sepw_pkg::CMD_START);
			wbyte(i == 0 ? {sepw_pkg::DEV_CODE, ~cs, 1'b0} : {4'h5, cs, 1'b0});
			`CHK(st[8], 1'b0)
			cmd(1'b0, sepw_pkg::CMD_STOP);
		end
		final_report();
	end
endmodule : serial_eeprom_page_write_read_bench
